// [verilog/iox_pkg.sv]
/*
 * Shared constants, carrier types and state encoding of the sixteen-line
 * serial-bus I/O expander.
 * Assumes a two-wire serial controller on the far side of the link and
 * pins that are asynchronous to both clocks.
 */
package iox_pkg;
    localparam logic [3:0] ADDR_FIXED   = 4'h4;   // fixed upper address bits, value arbitrary
    localparam logic [1:0] SEL_INPUT    = 2'h0;
    localparam logic [1:0] SEL_OUTPUT   = 2'h1;
    localparam logic [1:0] SEL_POLARITY = 2'h2;
    localparam logic [1:0] SEL_CONFIG   = 2'h3;
    localparam logic [7:0] OUT_RST      = 8'hff;
    localparam logic [7:0] POL_RST      = 8'h00;
    localparam logic [7:0] CFG_RST      = 8'hff;
    localparam logic [7:0] PTR_RST      = 8'h00;
    localparam logic [2:0] BIT_LAST     = 3'h7;
    localparam int unsigned PIN_SYNC_W  = 21;
    localparam int unsigned SCL_MIN_PERIOD_NS = 2500;
    localparam int unsigned LINK_CLK_NS       = 125;
    localparam int unsigned SCL_MIN_PERIOD_CYC = SCL_MIN_PERIOD_NS / LINK_CLK_NS;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } iox_pair_type;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK,
        ST_RD_NEXT
    } iox_state_type;
endpackage

// [verilog/iox_sync.sv]
/*
 * Two-stage level synchroniser, no reset on the data path.
 * Assumes the destination clock drives clk_in; only the second stage is read.
 */
module iox_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_in) begin
        stage1 <= d_in;
        q_out  <= stage1;
    end
endmodule

// [verilog/iox_top.sv]
/*
 * Sixteen-line I/O expander: two-wire serial target and register file on
 * the link clock, pin drivers and alert driver on the reference clock.
 * Assumes link_clk_in runs freely at least 8 times the bus clock and that
 * rstn_in is held low long enough to pass into the link domain.
 */
module iox_top
    import iox_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       link_clk_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out_out,
    output logic            sda_oe_out,
    input  wire logic       addr_strap_0_in,
    input  wire logic       addr_strap_1_in,
    input  wire logic       addr_strap_2_in,
    input  wire logic [7:0] port_lo_in,
    input  wire logic [7:0] port_hi_in,
    output logic      [7:0] port_lo_out,
    output logic      [7:0] port_hi_out,
    output logic      [7:0] port_lo_oe_out,
    output logic      [7:0] port_hi_oe_out,
    output logic            alert_n_out,
    output logic            alert_n_oe_out
);
    // link domain
    logic                  link_rstn;
    logic [PIN_SYNC_W-1:0] pin_sync;
    iox_pair_type          pins;
    logic [2:0]            straps;
    logic                  scl_s;
    logic                  sda_s;
    logic                  scl_q;
    logic                  sda_q;
    iox_state_type         state;
    logic [2:0]            cnt;
    logic [7:0]            shreg;
    logic [7:0]            tx;
    logic                  rw;
    logic                  ack_on;
    logic                  sda_oe;
    logic                  sda_lvl;
    logic [7:0]            ptr;
    iox_pair_type          out_reg;
    iox_pair_type          pol_reg;
    iox_pair_type          cfg_reg;
    iox_pair_type          snap;
    logic                  snap_valid;
    logic                  alert_l;
    logic                  xfer_tgl;
    // reference domain
    logic                  xfer_s;
    logic                  xfer_seen;
    logic                  alert_s;
    iox_pair_type          drv_en;
    iox_pair_type          drv_val;
    logic                  alert_drv;
    logic                  alert_lvl;

    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_cond;
    logic                  stop_cond;
    logic [7:0]            byte_in;
    logic                  addr_hit;
    logic                  addr_done;
    logic                  cmd_done;
    logic                  wr_done;
    logic                  load_now;
    logic [7:0]            rd_byte;
    logic [7:0]            in_view;

    function automatic logic [7:0] pick(input iox_pair_type pair, input logic hi);
        pick = hi ? pair.hi : pair.lo;
    endfunction

    // register selected by the low three pointer bits
    function automatic logic [7:0] read_byte(input logic [7:0] p, input iox_pair_type pv,
                                             input iox_pair_type pol, input iox_pair_type outv,
                                             input iox_pair_type cfg);
        logic [7:0] r;
        r = 8'h00;
        unique case (p[2:1])
            SEL_INPUT:    r = pick(pv, p[0]) ^ pick(pol, p[0]);
            SEL_OUTPUT:   r = pick(outv, p[0]);
            SEL_POLARITY: r = pick(pol, p[0]);
            SEL_CONFIG:   r = pick(cfg, p[0]);
        endcase
        return r;
    endfunction

    iox_sync #(.WIDTH(1)) u_rst_sync (
        .clk_in (link_clk_in),
        .d_in   (rstn_in),
        .q_out  (link_rstn)
    );

    iox_sync #(.WIDTH(PIN_SYNC_W)) u_pin_sync (
        .clk_in (link_clk_in),
        .d_in   ({scl_in, sda_in, addr_strap_2_in, addr_strap_1_in, addr_strap_0_in, port_hi_in, port_lo_in}),
        .q_out  (pin_sync)
    );

    assign {scl_s, sda_s, straps} = pin_sync[PIN_SYNC_W-1:16];
    assign pins     = pin_sync[15:0];

    // bus sampled at 8x or more of the fastest bus clock
    assign scl_rise   = scl_s & ~scl_q;
    assign scl_fall   = ~scl_s & scl_q;
    assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_cond  = scl_s & scl_q & ~sda_q & sda_s;
    assign byte_in    = {shreg[6:0], sda_s};
    assign addr_hit   = byte_in[7:1] == {ADDR_FIXED, straps};
    assign addr_done  = scl_rise && state == ST_ADDR && cnt == BIT_LAST;
    assign cmd_done   = scl_rise && state == ST_CMD && cnt == BIT_LAST;
    assign wr_done    = scl_rise && state == ST_WR && cnt == BIT_LAST;
    assign load_now   = scl_fall && ((state == ST_ADDR_ACK && ack_on && rw) || state == ST_RD_NEXT);
    assign rd_byte    = read_byte(ptr, pins, pol_reg, out_reg, cfg_reg);
    assign in_view    = pick(pins, ptr[0]) ^ pick(pol_reg, ptr[0]);

    always_ff @(posedge link_clk_in) begin
        sda_lvl <= 1'b0;                                       // open drain: only the enable moves
        if (!link_rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // serial target engine
    always_ff @(posedge link_clk_in) begin
        if (!link_rstn) begin
            state  <= ST_IDLE;
            cnt    <= 3'h0;
            shreg  <= 8'h00;
            tx     <= 8'h00;
            rw     <= 1'b0;
            ack_on <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_cond) begin
            state  <= ST_ADDR;
            cnt    <= 3'h0;
            ack_on <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            state  <= ST_IDLE;
            ack_on <= 1'b0;
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            unique case (state)
                ST_ADDR: begin
                    shreg <= byte_in;
                    cnt   <= cnt + 3'h1;
                    if (cnt == BIT_LAST) begin
                        if (addr_hit) begin
                            rw    <= sda_s;
                            state <= ST_ADDR_ACK;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_CMD, ST_WR: begin
                    shreg <= byte_in;
                    cnt   <= cnt + 3'h1;
                    if (cnt == BIT_LAST) begin
                        state <= (state == ST_CMD) ? ST_CMD_ACK : ST_WR_ACK;
                    end
                end
                ST_RD: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == BIT_LAST) begin
                        state <= ST_RD_ACK;
                    end
                end
                ST_RD_ACK: begin
                    cnt   <= 3'h0;
                    state <= sda_s ? ST_IDLE : ST_RD_NEXT;
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (state)
                ST_ADDR_ACK, ST_CMD_ACK, ST_WR_ACK: begin
                    if (!ack_on) begin
                        ack_on <= 1'b1;
                        sda_oe <= 1'b1;
                    end else begin
                        ack_on <= 1'b0;
                        cnt    <= 3'h0;
                        sda_oe <= 1'b0;
                        if (state == ST_ADDR_ACK && rw) begin
                            tx     <= rd_byte;
                            sda_oe <= ~rd_byte[7];
                            state  <= ST_RD;
                        end else begin
                            state  <= (state == ST_ADDR_ACK) ? ST_CMD : ST_WR;
                        end
                    end
                end
                ST_RD: begin
                    tx     <= {tx[6:0], 1'b0};
                    sda_oe <= ~tx[6];
                end
                ST_RD_ACK: sda_oe <= 1'b0;
                ST_RD_NEXT: begin
                    tx     <= rd_byte;
                    sda_oe <= ~rd_byte[7];
                    state  <= ST_RD;
                end
                default: ;
            endcase
        end
    end

    // command pointer, alternates within a register pair per data byte
    always_ff @(posedge link_clk_in) begin
        if (!link_rstn) begin
            ptr <= PTR_RST;
        end else if (cmd_done) begin
            ptr <= byte_in;
        end else if (wr_done || (scl_rise && state == ST_RD_ACK)) begin
            ptr[0] <= ~ptr[0];
        end
    end

    // register writes; direction and output changes announced by a toggle
    always_ff @(posedge link_clk_in) begin
        if (!link_rstn) begin
            out_reg  <= {OUT_RST, OUT_RST};
            pol_reg  <= {POL_RST, POL_RST};
            cfg_reg  <= {CFG_RST, CFG_RST};
            xfer_tgl <= 1'b0;
        end else if (wr_done) begin
            unique case (ptr[2:1])
                SEL_INPUT: ;
                SEL_OUTPUT: begin
                    if (ptr[0]) out_reg.hi <= byte_in;
                    else out_reg.lo <= byte_in;
                    xfer_tgl <= ~xfer_tgl;
                end
                SEL_POLARITY: begin
                    if (ptr[0]) pol_reg.hi <= byte_in;
                    else pol_reg.lo <= byte_in;
                end
                SEL_CONFIG: begin
                    if (ptr[0]) cfg_reg.hi <= byte_in;
                    else cfg_reg.lo <= byte_in;
                    xfer_tgl <= ~xfer_tgl;
                end
            endcase
        end
    end

    // captured input state and change alert
    always_ff @(posedge link_clk_in) begin
        if (!link_rstn) begin
            snap       <= '0;
            snap_valid <= 1'b0;
            alert_l    <= 1'b0;
        end else begin
            alert_l <= snap_valid && (pins != snap);
            if (!snap_valid) begin
                snap       <= pins;
                snap_valid <= 1'b1;
            end else if (load_now && ptr[2:1] == SEL_INPUT) begin
                if (ptr[0]) snap.hi <= pins.hi;
                else snap.lo <= pins.lo;
            end
        end
    end

    iox_sync #(.WIDTH(1)) u_xfer_sync (
        .clk_in (ref_clk_in),
        .d_in   (xfer_tgl),
        .q_out  (xfer_s)
    );
    iox_sync #(.WIDTH(1)) u_alert_sync (
        .clk_in (ref_clk_in),
        .d_in   (alert_l),
        .q_out  (alert_s)
    );

    // pin drivers take the held link words once the toggle has crossed
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            xfer_seen <= 1'b0;
            drv_en    <= '0;
            drv_val   <= {OUT_RST, OUT_RST};
            alert_drv <= 1'b0;
            alert_lvl <= 1'b0;
        end else begin
            xfer_seen <= xfer_s;
            alert_drv <= alert_s;
            alert_lvl <= 1'b0;
            if (xfer_s != xfer_seen) begin
                drv_en  <= ~cfg_reg;
                drv_val <= out_reg;
            end
        end
    end

    assign port_lo_out    = drv_val.lo;
    assign port_hi_out    = drv_val.hi;
    assign port_lo_oe_out = drv_en.lo;
    assign port_hi_oe_out = drv_en.hi;
    assign alert_n_out    = alert_lvl;
    assign alert_n_oe_out = alert_drv;
    assign sda_out_out    = sda_lvl;
    assign sda_oe_out     = sda_oe;

    sequence s_addr_ok;
        addr_done && addr_hit;
    endsequence
    sequence s_ack_low;
        ##[1:1000] (sda_oe && state == ST_ADDR_ACK);
    endsequence
    sequence s_toggle_seen;
        xfer_s != xfer_seen;
    endsequence

    AST_RESET_HIZ: assert property (@(posedge ref_clk_in) !rstn_in |=> drv_en == '0)
        else $error("lines not released after reset");
    AST_OE_FROM_CFG: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        s_toggle_seen |=> drv_en == ~$past(cfg_reg))
        else $error("drive enable does not follow direction bits");
    AST_OUT_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        !(xfer_s != xfer_seen) ##1 !(xfer_s != xfer_seen) |-> $stable(drv_val) && $stable(drv_en))
        else $error("pin drive changed without a register write");
    AST_ALERT_SET: assert property (@(posedge link_clk_in) disable iff (!link_rstn)
        snap_valid && pins != snap |=> alert_l)
        else $error("alert not raised on a changed line");
    AST_ALERT_PIN: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        alert_s |=> alert_n_oe_out && !alert_n_out)
        else $error("alert pin not pulled low for a changed line");
    AST_ALERT_CLEAR: assert property (@(posedge link_clk_in) disable iff (!link_rstn)
        snap_valid && pins == snap |=> !alert_l)
        else $error("alert held with lines at captured state");
    AST_POL_INVERT: assert property (@(posedge link_clk_in) disable iff (!link_rstn)
        load_now && ptr[2:1] == SEL_INPUT |=> tx == $past(in_view))
        else $error("input byte not polarity adjusted");
    AST_CMD_PTR: assert property (@(posedge link_clk_in) disable iff (!link_rstn)
        cmd_done |=> ptr == $past(byte_in) && state == ST_CMD_ACK)
        else $error("command byte not stored in pointer");
    AST_INPUT_WR_IGNORED: assert property (@(posedge link_clk_in) disable iff (!link_rstn)
        wr_done && ptr[2:1] == SEL_INPUT |=> $stable(out_reg) && $stable(pol_reg) && $stable(cfg_reg))
        else $error("write to input register changed state");
    AST_FOREIGN_ADDR: assert property (@(posedge link_clk_in) disable iff (!link_rstn)
        addr_done && !addr_hit |=> state == ST_IDLE && !sda_oe)
        else $error("foreign address not ignored");
    AST_ACK_ADDR: assert property (@(posedge link_clk_in) disable iff (!link_rstn)
        s_addr_ok |-> s_ack_low or ##[1:1000] (start_cond || stop_cond))
        else $error("matching address not acknowledged");
    AST_RW_BIT: assert property (@(posedge link_clk_in) disable iff (!link_rstn)
        s_addr_ok |=> rw == $past(sda_s))
        else $error("direction bit not taken from last address bit");
endmodule

// [testbench/iox_bus_ctrl.sv]
/*
 * Two-wire bus controller model that drives the expander's serial target.
 * Assumes an external pull-up: the data line is high unless some party pulls it.
 */
module iox_bus_ctrl (
    input  wire logic        sda_in,
    input  wire logic [15:0] half_ns_in,
    output logic             scl_out,
    output logic             sda_low_out,
    output logic             ack_valid_out,
    output logic             ack_out,
    output logic             rd_valid_out,
    output logic      [7:0]  rd_data_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        ack_valid_out = 1'b0;
        ack_out = 1'b1;
        rd_valid_out = 1'b0;
        rd_data_out = 8'h00;
    end

    // data moves an eighth of a period after the clock falls, clear of the edge
    task automatic send_bit(input logic b);
        #(half_ns_in / 4) sda_low_out = ~b;
        #(half_ns_in - half_ns_in / 4) scl_out = 1'b1;
        #(half_ns_in) scl_out = 1'b0;
    endtask

    // line released, sampled in the middle of the high phase
    task automatic take_bit(output logic b);
        #(half_ns_in / 4) sda_low_out = 1'b0;
        #(half_ns_in - half_ns_in / 4) scl_out = 1'b1;
        #(half_ns_in / 2) b = sda_in;
        #(half_ns_in / 2) scl_out = 1'b0;
    endtask

    // serves as first and as repeated start
    task automatic start();
        #(half_ns_in / 4) sda_low_out = 1'b0;
        #(half_ns_in - half_ns_in / 4) scl_out = 1'b1;
        #(half_ns_in) sda_low_out = 1'b1;
        #(half_ns_in) scl_out = 1'b0;
    endtask

    task automatic stop();
        #(half_ns_in / 4) sda_low_out = 1'b1;
        #(half_ns_in - half_ns_in / 4) scl_out = 1'b1;
        #(half_ns_in) sda_low_out = 1'b0;
        #(half_ns_in);
    endtask

    task automatic put_byte(input logic [7:0] b);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i]);
        end
        take_bit(a);
        ack_out = a;
        #1 ack_valid_out = 1'b1;
        #1 ack_valid_out = 1'b0;
    endtask

    // last byte answered with a release, others pulled low
    task automatic get_byte(input logic last);
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) begin
            take_bit(d[i]);
        end
        rd_data_out = d;
        #1 rd_valid_out = 1'b1;
        #1 rd_valid_out = 1'b0;
        send_bit(last);
    endtask
endmodule

// [testbench/test_i2c_sixteen_bit_io_expander.sv]
/*
 * Self-checking bench of the sixteen-line expander with random port stimulus.
 * Assumes the controller model iox_bus_ctrl and pull-ups on the data line.
 */
module test_i2c_sixteen_bit_io_expander
    import iox_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         ref_clk  = 1'b0;
    logic         link_clk = 1'b0;
    logic         rstn     = 1'b0;
    logic [2:0]   strap    = 3'h0;
    logic [15:0]  half_ns  = 16'h04e2;
    iox_pair_type ext      = '0;
    iox_pair_type pins, oe, outv;
    logic         sda, scl, ctrl_low, sda_oe, sda_out, alert_oe, alert_n;
    logic         ack_valid, ack, rd_valid;
    logic [7:0]   rd_data;
    logic         ack_q[$];
    logic [7:0]   byte_q[$];
    int           num_errors = 0;
    int           compares   = 0;

    always #12.5 ref_clk = ~ref_clk;
    initial begin
        #7.3;
        forever #62.5 link_clk = ~link_clk;
    end

    assign sda  = ~(ctrl_low | (sda_oe & ~sda_out));
    assign pins = (oe & outv) | (~oe & ext);

    iox_top u_iox_top (
        .ref_clk_in(ref_clk), .rstn_in(rstn), .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda),
        .sda_out_out(sda_out), .sda_oe_out(sda_oe), .addr_strap_0_in(strap[0]), .addr_strap_1_in(strap[1]),
        .addr_strap_2_in(strap[2]), .port_lo_in(pins.lo), .port_hi_in(pins.hi), .port_lo_out(outv.lo),
        .port_hi_out(outv.hi), .port_lo_oe_out(oe.lo), .port_hi_oe_out(oe.hi), .alert_n_out(alert_n),
        .alert_n_oe_out(alert_oe)
    );

    iox_bus_ctrl u_iox_bus_ctrl (
        .sda_in(sda), .half_ns_in(half_ns), .scl_out(scl), .sda_low_out(ctrl_low), .ack_valid_out(ack_valid),
        .ack_out(ack), .rd_valid_out(rd_valid), .rd_data_out(rd_data)
    );

    task automatic check_bit(input string name, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h got %h", name, e, g);
        end
    endtask

    task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h got %h", name, e, g);
        end
    endtask

    task automatic check_pair(input string name, input iox_pair_type e, input iox_pair_type g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h got %h", name, e, g);
        end
    endtask

    always @(posedge ack_valid) check_bit("ack", ack_q.size() > 0 ? ack_q.pop_front() : 1'bx, ack);
    always @(posedge rd_valid) check_byte("read", byte_q.size() > 0 ? byte_q.pop_front() : 8'hxx, rd_data);

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    function automatic logic [7:0] addr(input logic [2:0] s, input logic rd);
        return {ADDR_FIXED, s, rd};
    endfunction

    // a foreign address must be refused on every byte
    task automatic wr_pair(input logic [7:0] a, input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1);
        repeat (4) ack_q.push_back(a !== addr(strap, 1'b0));
        u_iox_bus_ctrl.start();
        u_iox_bus_ctrl.put_byte(a);
        u_iox_bus_ctrl.put_byte(cmd);
        u_iox_bus_ctrl.put_byte(d0);
        u_iox_bus_ctrl.put_byte(d1);
        u_iox_bus_ctrl.stop();
    endtask

    task automatic rd_pair(input logic [7:0] cmd, input logic [7:0] e0, input logic [7:0] e1);
        repeat (3) ack_q.push_back(1'b0);
        byte_q.push_back(e0);
        byte_q.push_back(e1);
        u_iox_bus_ctrl.start();
        u_iox_bus_ctrl.put_byte(addr(strap, 1'b0));
        u_iox_bus_ctrl.put_byte(cmd);
        u_iox_bus_ctrl.start();
        u_iox_bus_ctrl.put_byte(addr(strap, 1'b1));
        u_iox_bus_ctrl.get_byte(1'b0);
        u_iox_bus_ctrl.get_byte(1'b1);
        u_iox_bus_ctrl.stop();
    endtask

    task automatic wait_alert(input logic lvl);
        for (int i = 0; i < 200 && alert_oe !== lvl; i++) @(negedge ref_clk);
        check_bit("alert", lvl, alert_oe);
    endtask

    // link side gets twenty link clocks of reset
    task automatic do_reset();
        cyc(1);
        rstn <= 1'b0;
        cyc(100);
        rstn <= 1'b1;
        cyc(40);
        @(negedge ref_clk);
        check_pair("oe", 16'h0000, oe);
        check_pair("drive", 16'hffff, outv);
        check_bit("alert", 1'b0, alert_oe);
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (98000) @(posedge ref_clk);
        num_errors++;
        end_of_test();
    end

    initial begin
        iox_pair_type o, c, p, want;
        void'($urandom(32'hd6d4));
        o = iox_pair_type'($urandom);
        p = iox_pair_type'($urandom);
        c = {8'hff, 8'($urandom) & 8'h7f};
        ext <= iox_pair_type'($urandom);
        do_reset();
        check_bit("alert_level", 1'b0, alert_n);
        wr_pair(addr(strap, 1'b0), 8'h02, o.lo, o.hi);
        wr_pair(addr(strap, 1'b0), 8'h06, c.lo, c.hi);
        cyc(40);
        @(negedge ref_clk);
        check_pair("oe", iox_pair_type'(~c), oe);
        check_pair("drive", o, outv);
        rd_pair(8'hfa, o.lo, o.hi);
        half_ns = 16'h1388;
        wr_pair(addr(strap, 1'b0), 8'h04, p.lo, p.hi);
        half_ns = 16'h04e2;
        want = (o & ~c) | (ext & c);
        rd_pair(8'h00, want.lo ^ p.lo, want.hi ^ p.hi);
        wait_alert(1'b0);
        cyc(1);
        ext.hi <= ext.hi ^ 8'h10;
        wait_alert(1'b1);
        cyc(1);
        ext.hi <= ext.hi ^ 8'h10;
        wait_alert(1'b0);
        cyc(1);
        ext.hi <= ext.hi ^ 8'h80;
        wait_alert(1'b1);
        wr_pair(addr(strap, 1'b0), 8'h01, 8'h3c, 8'hc3);
        check_bit("alert", 1'b1, alert_oe);
        want = (o & ~c) | (ext & c);
        rd_pair(8'h01, want.hi ^ p.hi, want.lo ^ p.lo);
        wait_alert(1'b0);
        wr_pair(addr(~strap, 1'b0), 8'h02, 8'h00, 8'h00);
        cyc(40);
        @(negedge ref_clk);
        check_pair("drive", o, outv);
        do_reset();
        rd_pair(8'h02, 8'hff, 8'hff);
        rd_pair(8'h04, 8'h00, 8'h00);
        rd_pair(8'h06, 8'hff, 8'hff);
        rd_pair(8'h00, ext.lo, ext.hi);
        for (int s = 0; s < 8; s++) begin
            cyc(1);
            strap <= 3'(s);
            cyc(20);
            ack_q.push_back(1'b0);
            ack_q.push_back(1'b1);
            u_iox_bus_ctrl.start();
            u_iox_bus_ctrl.put_byte(addr(3'(s), 1'b0));
            u_iox_bus_ctrl.stop();
            u_iox_bus_ctrl.start();
            u_iox_bus_ctrl.put_byte(addr(3'(s) ^ 3'h2, 1'b1));
            u_iox_bus_ctrl.stop();
        end
        cyc(20);
        end_of_test();
    end
endmodule
